// File: rtl/swc_sleep_ctrl.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module swc_sleep_ctrl #(
  parameter int N_SRC   = 8,
  parameter int PC_W    = 13,
  parameter int WDT_CYC = swc_pkg::WDT_CYC,
  parameter int OST_CYC = swc_pkg::OST_TOSC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [17:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // core side
  input  wire logic              sleepExec,
  input  wire logic [PC_W-1:0]   corePc,
  input  wire logic              wdtClear,
  output logic                   coreStall,
  output logic                   sleepNop,
  output logic                   fetchEn,
  output logic [PC_W-1:0]        fetchAddr,
  output logic                   vectorReq,
  output logic [PC_W-1:0]        vectorAddr,
  output logic                   internalReset,
  // interrupt sources
  input  wire logic [N_SRC-1:0]  srcFlag,
  // pins
  input  wire logic              master_clear_pin,
  output logic                   masterClearOut,
  output logic                   masterClearOe,
  input  wire logic [7:0]        portOut,
  input  wire logic [7:0]        portOe,
  output logic [7:0]             padOut,
  output logic [7:0]             padOe,
  output logic                   oscDriverEn,
  output logic                   power_down_flag,
  output logic                   expiry_flag,
  // interrupt line
  output logic                   irq
);
  // elaboration-time refusal of values the logic cannot serve
  if (N_SRC < 1 || N_SRC > 8 || PC_W < 4 || WDT_CYC < 2 || OST_CYC < 1)
  begin : g_bad_param
    $error("swc_sleep_ctrl: unsupported parameter value");
  end

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_OST, ST_RESUME} swc_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  swc_state_e             state_reg;          // power state
  logic [7:0]             option_control_reg; // option bits
  logic [7:0]             config_word_reg;    // configuration bits
  logic [N_SRC-1:0]       srcEnable_reg;      // per source wake enables
  logic                   gie_reg;            // global_irq_enable
  logic [swc_pkg::EV_W-1:0] evStat_reg;       // sticky events
  logic [swc_pkg::EV_W-1:0] evEn_reg;         // event mask
  logic [31:0]            wdtCnt_reg;         // watchdog count
  logic [31:0]            ostCnt_reg;         // start-up count
  logic                   pd_reg;             // power_down_flag
  logic                   to_reg;             // expiry_flag
  logic                   vecPending_reg;     // vector after resumed instruction
  logic [7:0]             holdOut_reg;        // frozen port data
  logic [7:0]             holdOe_reg;         // frozen port enables
  logic [PC_W-1:0]        nextPc_reg;         // prefetched address

  logic                   wakeReq;
  logic                   wdtEn;
  logic                   wdtExpire;
  logic                   sleepGo;
  logic                   sleepBlock;
  logic                   rcMode;
  logic [31:0]            ostLoad;
  logic                   wr;
  logic                   rd;
  logic [15:0]            idx;
  logic                   hit;
  logic [swc_pkg::EV_W-1:0] evSet;

  ////////////////////////////////////////////////////////////////////////////
  // wake request from enabled sources
  swc_wake_req #(.N(N_SRC)) u_wake (
    .srcFlag   (srcFlag),
    .srcEnable (srcEnable_reg),
    .wakeReq   (wakeReq)
  );

  assign wdtEn      = config_word_reg[swc_pkg::CFG_WDT_BIT];
  assign wdtExpire  = wdtEn && (wdtCnt_reg == 32'(WDT_CYC - 1));
  // global disabled with a pending enabled source turns sleep into a no-op
  assign sleepBlock = !gie_reg && wakeReq;
  assign sleepGo    = (state_reg == ST_RUN) && sleepExec && !sleepBlock;
  assign sleepNop   = (state_reg == ST_RUN) && sleepExec && sleepBlock;
  // rc mode when oscillator select bits FOSC2 and FOSC1 are both high, FOSC0 not used
  assign rcMode     = config_word_reg[swc_pkg::CFG_FOSC2] &&
                      config_word_reg[swc_pkg::CFG_FOSC1];
  assign ostLoad    = rcMode ? 32'(swc_pkg::RC_CYC) : 32'(OST_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // power state machine
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      state_reg <= ST_RUN;
    else if (!master_clear_pin)
      state_reg <= ST_RUN;                       // master clear resets
    else
    begin
      unique case (state_reg)
        ST_RUN:
          if (sleepGo)
            state_reg <= ST_SLEEP;
        ST_SLEEP:
          if (wakeReq || wdtExpire)              // continuation wakes
            state_reg <= ST_OST;
        ST_OST:
          if (ostCnt_reg == 32'd1)
            state_reg <= ST_RESUME;              // start-up elapsed
        ST_RESUME:
          state_reg <= ST_RUN;                   // run instruction after sleep
      endcase
    end
  end

  // oscillator start-up counter
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      ostCnt_reg <= 32'd0;
    else if (state_reg == ST_SLEEP)
      ostCnt_reg <= ostLoad;
    else if (state_reg == ST_OST && ostCnt_reg != 32'd0)
      ostCnt_reg <= ostCnt_reg - 32'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: keeps running asleep, cleared on sleep and on source or expiry wakes, not on master clear
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      wdtCnt_reg <= 32'd0;
    else if (!wdtEn)
      wdtCnt_reg <= 32'd0;
    else if (sleepGo || wdtClear || wdtExpire)
      wdtCnt_reg <= 32'd0;
    else if (state_reg == ST_SLEEP && wakeReq)
      wdtCnt_reg <= 32'd0;
    else
      wdtCnt_reg <= wdtCnt_reg + 32'd1;
  end

  // awake expiry resets the core internally; the pin is never pulled
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      internalReset <= 1'b0;
    else
      internalReset <= wdtExpire && (state_reg != ST_SLEEP) && (state_reg != ST_OST);
  end
  assign masterClearOut = 1'b0;
  assign masterClearOe  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // power-down and expiry flags
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pd_reg <= 1'b1;                            // set at power-up
      to_reg <= 1'b1;
    end
    else if (sleepGo)
    begin
      pd_reg <= 1'b0;
      to_reg <= 1'b1;
    end
    else if (wdtExpire)
      to_reg <= 1'b0;                            // watchdog caused it
    else if (wdtClear)
    begin
      pd_reg <= 1'b1;
      to_reg <= 1'b1;
    end
  end
  assign power_down_flag = pd_reg;
  assign expiry_flag     = to_reg;

  ////////////////////////////////////////////////////////////////////////////
  // prefetch of the instruction after sleep and vector decision
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      nextPc_reg <= '0;
    else if (sleepExec && state_reg == ST_RUN)
      nextPc_reg <= corePc + PC_W'(1);
  end
  assign fetchEn   = (state_reg == ST_RUN) && sleepExec;
  assign fetchAddr = nextPc_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      vecPending_reg <= 1'b0;
    else if (state_reg == ST_SLEEP && wakeReq)
      vecPending_reg <= gie_reg;
    else if (state_reg == ST_RUN)
      vecPending_reg <= 1'b0;
  end
  // raised one cycle after resume, i.e. after the in-line instruction
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      vectorReq <= 1'b0;
    else
      vectorReq <= (state_reg == ST_RESUME) && vecPending_reg;
  end
  assign vectorAddr = PC_W'(swc_pkg::IRQ_VECTOR);

  assign coreStall   = (state_reg != ST_RUN);
  assign oscDriverEn = (state_reg == ST_RUN) || (state_reg == ST_RESUME) ||
                       (state_reg == ST_OST);    // off only while asleep

  ////////////////////////////////////////////////////////////////////////////
  // port hold: snapshot at entry, replayed until the core runs again
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      holdOut_reg <= 8'h00;
      holdOe_reg  <= 8'h00;
    end
    else if (sleepGo)
    begin
      holdOut_reg <= portOut;
      holdOe_reg  <= portOe;
    end
  end
  assign padOut = (state_reg == ST_RUN) ? portOut : holdOut_reg;
  assign padOe  = (state_reg == ST_RUN) ? portOe  : holdOe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, unmapped index answers with pslverr
  assign idx   = paddr[17:2];
  assign wr    = psel && penable && pwrite;
  assign rd    = psel && penable && !pwrite;
  assign hit   = (idx == swc_pkg::OPTION_IDX) || (idx == swc_pkg::CONFIG_IDX) ||
                 (idx == swc_pkg::STATUS_IDX) || (idx == swc_pkg::IRQ_STAT_IDX) ||
                 (idx == swc_pkg::IRQ_CLR_IDX) || (idx == swc_pkg::IRQ_EN_IDX) ||
                 (idx == swc_pkg::SRC_EN_IDX) || (idx == swc_pkg::CTRL_IDX);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // writable registers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      option_control_reg <= swc_pkg::OPTION_RST;
      config_word_reg    <= swc_pkg::CONFIG_RST;
      srcEnable_reg      <= '0;
      gie_reg            <= 1'b0;
      evEn_reg           <= '0;
    end
    else if (wr)
    begin
      if (idx == swc_pkg::OPTION_IDX)
        option_control_reg <= pwdata[7:0];
      if (idx == swc_pkg::CONFIG_IDX)
        config_word_reg <= pwdata[7:0];
      if (idx == swc_pkg::SRC_EN_IDX)
        srcEnable_reg <= pwdata[N_SRC-1:0];
      if (idx == swc_pkg::CTRL_IDX)
        gie_reg <= pwdata[swc_pkg::CTRL_GIE_BIT];
      if (idx == swc_pkg::IRQ_EN_IDX)
        evEn_reg <= pwdata[swc_pkg::EV_W-1:0];
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  assign evSet = {sleepNop, wdtExpire, (state_reg == ST_OST && ostCnt_reg == 32'd1),
                  sleepGo};
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      evStat_reg <= '0;
    else if (wr && idx == swc_pkg::IRQ_CLR_IDX)
      evStat_reg <= (evStat_reg & ~pwdata[swc_pkg::EV_W-1:0]) | evSet;
    else
      evStat_reg <= evStat_reg | evSet;
  end
  assign irq = |(evStat_reg & evEn_reg);

  // read data registered at the setup phase
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (1'b1)
        idx == swc_pkg::OPTION_IDX:   prdata <= {24'h0, option_control_reg};
        idx == swc_pkg::CONFIG_IDX:   prdata <= {24'h0, config_word_reg};
        idx == swc_pkg::STATUS_IDX:   prdata <= {29'h0, state_reg == ST_SLEEP, to_reg, pd_reg};
        idx == swc_pkg::IRQ_STAT_IDX: prdata <= {28'h0, evStat_reg};
        idx == swc_pkg::IRQ_EN_IDX:   prdata <= {28'h0, evEn_reg};
        idx == swc_pkg::SRC_EN_IDX:   prdata <= 32'(srcEnable_reg);
        idx == swc_pkg::CTRL_IDX:     prdata <= {31'h0, gie_reg};
        default:                      prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: include/swc_pkg.sv
package swc_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [15:0] OPTION_IDX   = 16'h0081;
  localparam logic [15:0] CONFIG_IDX   = 16'h2007;
  localparam logic [15:0] STATUS_IDX   = 16'h0100;
  localparam logic [15:0] IRQ_STAT_IDX = 16'h0101;
  localparam logic [15:0] IRQ_CLR_IDX  = 16'h0102;
  localparam logic [15:0] IRQ_EN_IDX   = 16'h0103;
  localparam logic [15:0] SRC_EN_IDX   = 16'h0104;
  localparam logic [15:0] CTRL_IDX     = 16'h0105;
  // reset values
  localparam logic [7:0]  OPTION_RST   = 8'hFF;
  localparam logic [7:0]  CONFIG_RST   = 8'hFF;
  // configuration and option fields
  localparam int          CFG_WDT_BIT  = 2;
  localparam int          CFG_FOSC2    = 4;
  localparam int          CFG_FOSC1    = 1;
  localparam int          CFG_FOSC0    = 0;
  localparam int          OPT_PSA_BIT  = 3;
  // control register fields
  localparam int          CTRL_GIE_BIT = 0;
  // status fields
  localparam int          ST_PD_BIT    = 0;
  localparam int          ST_TO_BIT    = 1;
  localparam int          ST_SLEEP_BIT = 2;
  // sticky event bits
  localparam int          EV_SLEEP     = 0;
  localparam int          EV_WAKE      = 1;
  localparam int          EV_WDT       = 2;
  localparam int          EV_NOP       = 3;
  localparam int          EV_W         = 4;
  // vector and timing
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam int          OST_TOSC     = 1024;
  localparam int          RC_DELAY_NS  = 1000;
  localparam int          CLK_NS       = 8;
  localparam int          RC_CYC       = (RC_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int          WDT_MS       = 18;
  localparam int          WDT_CYC      = WDT_MS * 1000000 / CLK_NS;
endpackage

// File: rtl/swc_wake_req.sv
`timescale 1ns/1ps
// combines interrupt flags with their enables into one wake request
module swc_wake_req #(
  parameter int N = 8
) (
  // sources
  input  wire logic [N-1:0] srcFlag,
  input  wire logic [N-1:0] srcEnable,
  // result
  output logic              wakeReq
);
  logic [N-1:0] hit;
  // one and-gate per source; global enable deliberately not involved
  for (genvar i = 0; i < N; i++)
  begin : g_src
    assign hit[i] = srcFlag[i] & srcEnable[i];
  end
  assign wakeReq = |hit;
endmodule

// File: tb/swc_sleep_ctrl_props.sv
`timescale 1ns/1ps
// watches core-side and pin outputs of the sleep controller
module swc_sleep_ctrl_props #(
  parameter int PC_W = 13
) (
  // clock and reset
  input wire logic            ref_clk,
  input wire logic            nrst,
  // core side
  input wire logic            sleepExec,
  input wire logic [PC_W-1:0] corePc,
  input wire logic            coreStall,
  input wire logic            sleepNop,
  input wire logic            fetchEn,
  input wire logic [PC_W-1:0] fetchAddr,
  input wire logic            internalReset,
  // pins and flags
  input wire logic            master_clear_pin,
  input wire logic            masterClearOut,
  input wire logic            masterClearOe,
  input wire logic [7:0]      padOut,
  input wire logic [7:0]      padOe,
  input wire logic            oscDriverEn,
  input wire logic            power_down_flag,
  input wire logic            expiry_flag
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  chk_sleep_entry: assert property (
    sleepExec && !coreStall && !sleepNop && master_clear_pin
    |=> !oscDriverEn && !power_down_flag && expiry_flag)
    else $error("sleep entry outputs wrong");
  chk_osc_cause: assert property ($fell(oscDriverEn) |-> $past(sleepExec))
    else $error("oscillator stopped without sleep");
  chk_nop_stays: assert property (sleepNop |=> oscDriverEn && !coreStall)
    else $error("blocked sleep still stopped the core");
  // pads may not follow the core once it has stopped
  chk_pads_hold: assert property (
    coreStall && $past(coreStall) |-> $stable(padOut) && $stable(padOe))
    else $error("pad drive moved while stopped");
  chk_pin_quiet: assert property (!masterClearOe && !masterClearOut)
    else $error("master clear pin driven");
  chk_prefetch: assert property (
    sleepExec && !coreStall |-> fetchEn ##1 fetchAddr == $past(corePc) + PC_W'(1))
    else $error("prefetch address wrong");
  chk_powerup_flags: assert property ($rose(nrst) |-> power_down_flag && expiry_flag)
    else $error("flags not set after reset");
  // limitation: start-up length fixed at the bench's eight cycles
  chk_ost_wait: assert property (
    $rose(oscDriverEn) && master_clear_pin && $past(master_clear_pin)
    |-> coreStall [*8] ##[1:4] !coreStall)
    else $error("start-up wait length wrong");
  chk_no_sleep_reset: assert property (!$past(oscDriverEn) |-> !internalReset)
    else $error("reset raised during sleep");
  // main scenarios reached
  cov_sleep: cover property (sleepExec && !coreStall ##1 !oscDriverEn);
  cov_nop: cover property (sleepNop);
  cov_wake: cover property ($rose(oscDriverEn) ##[8:12] !coreStall);
endmodule
bind swc_sleep_ctrl swc_sleep_ctrl_props #(.PC_W(PC_W)) chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .sleepExec(sleepExec), .corePc(corePc),
  .coreStall(coreStall), .sleepNop(sleepNop), .fetchEn(fetchEn), .fetchAddr(fetchAddr),
  .internalReset(internalReset), .master_clear_pin(master_clear_pin),
  .masterClearOut(masterClearOut), .masterClearOe(masterClearOe), .padOut(padOut),
  .padOe(padOe), .oscDriverEn(oscDriverEn), .power_down_flag(power_down_flag),
  .expiry_flag(expiry_flag));

// File: tb/swc_core_model.sv
`timescale 1ns/1ps
// stands in for the core: program counter, port drive, sleep issue
module swc_core_model (
  // clock and reset
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  // bench request and stall
  input  wire logic  goSleep,
  input  wire logic  coreStall,
  // toward the controller
  output logic       sleepExec,
  output logic [12:0] corePc,
  output logic [7:0] portOut,
  output logic [7:0] portOe
);
  ////////////////////////////////////////////////////////////////
  // ports keep moving every cycle and pc whenever not stalled, so a missing pad freeze shows
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      corePc  <= 13'h0000;
      portOut <= 8'h5A;
    end
    else
    begin
      corePc  <= coreStall ? corePc : corePc + 13'h0001;
      portOut <= portOut + 8'h01;
    end
    portOe <= ~portOut;
  end
  // sleep is a one-cycle instruction from a running core only
  always_ff @(posedge ref_clk)
  begin
    sleepExec <= nrst && goSleep && !coreStall && !sleepExec;
  end
endmodule

// File: tb/swc_sleep_ctrl_tb.sv
`timescale 1ns/1ps
// self-checking bench for the sleep and wake controller
module swc_sleep_ctrl_tb;
  // apb and clock
  logic        ref_clk = 1'h0;
  logic        nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  // core side and pins
  logic        sleepExec, wdtClear, coreStall, sleepNop, fetchEn, vectorReq;
  logic        internalReset, master_clear_pin, masterClearOut, masterClearOe;
  logic        oscDriverEn, power_down_flag, expiry_flag, irq, goSleep;
  logic [12:0] corePc, fetchAddr, vectorAddr;
  logic [7:0]  srcFlag, portOut, portOe, padOut, padOe;
  // bookkeeping; rows hold index, value after reset, error flag
  int          fails = 0, total_checks = 0, nopCnt = 0, vecCnt = 0, rstCnt = 0, n, n0;
  logic [50:0] rows [8];
  ////////////////////////////////////////////////////////////////
  // short watchdog and start-up counts keep the run brief
  swc_sleep_ctrl #(.WDT_CYC(400), .OST_CYC(8)) dut_u (.*);
  swc_core_model model_u (.*);
  always #4 ref_clk = ~ref_clk;
  // one-cycle pulses are counted at the edge
  always @(posedge ref_clk)
  begin
    nopCnt <= nopCnt + int'(sleepNop === 1'h1);
    vecCnt <= vecCnt + int'(vectorReq === 1'h1);
    rstCnt <= rstCnt + int'(internalReset === 1'h1);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) fails++;
  endtask
  task automatic sleep_now;
    @(posedge ref_clk);
    wdtClear <= 1'h1;
    goSleep <= 1'h1;
    @(posedge ref_clk);
    wdtClear <= 1'h0;
    goSleep <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (coreStall !== 1'h0 && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the roughly one thousand cycles expected
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    close_out();
  end
  initial
  begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    wdtClear = 1'h0;
    goSleep = 1'h0;
    srcFlag = 8'h00;
    master_clear_pin = 1'h1;
    rows[0] = {swc_pkg::STATUS_IDX, 2'h0, 32'h3, 1'h0};
    rows[1] = {swc_pkg::IRQ_STAT_IDX, 2'h0, 32'h0, 1'h0};
    rows[2] = {swc_pkg::IRQ_EN_IDX, 2'h0, 32'h0, 1'h0};
    rows[3] = {swc_pkg::SRC_EN_IDX, 2'h0, 32'h0, 1'h0};
    rows[4] = {swc_pkg::CTRL_IDX, 2'h0, 32'h0, 1'h0};
    rows[5] = {swc_pkg::OPTION_IDX, 2'h0, 32'hFF, 1'h0};
    rows[6] = {swc_pkg::CONFIG_IDX, 2'h0, 32'hFF, 1'h0};
    rows[7] = {16'h0200, 2'h0, 32'h0, 1'h1};
    repeat (10) @(posedge ref_clk);
    nrst <= 1'h1;
    foreach (rows[i])
    begin
      apb(1'h0, rows[i][50:35], 32'h0);
      if (!rows[i][0]) chk(rd, rows[i][32:1], "reset value");
      chk({31'h0, err}, {31'h0, rows[i][0]}, "error response");
    end
    $display("test table done");
    // crystal mode with watchdog on, so the short start-up count applies
    apb(1'h1, swc_pkg::CONFIG_IDX, 32'h4);
    // enabled source wakes with global enable clear: no vector
    apb(1'h1, swc_pkg::SRC_EN_IDX, 32'h1);
    n0 = vecCnt;
    sleep_now();
    chk({31'h0, oscDriverEn}, 32'h0, "osc off");
    apb(1'h0, swc_pkg::STATUS_IDX, 32'h0);
    chk(rd, 32'h6, "status asleep");
    srcFlag <= 8'h01;
    wait_run(200);
    chk({31'h0, n >= 9 && n < 200}, 32'h1, "start-up wait");
    srcFlag <= 8'h00;
    repeat (4) @(posedge ref_clk);
    chk(vecCnt - n0, 32'h0, "vector seen");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'h0, swc_pkg::IRQ_STAT_IDX, 32'h0);
    chk(rd, 32'h3, "sleep and wake events");
    apb(1'h1, swc_pkg::IRQ_EN_IDX, 32'hF);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'h1, swc_pkg::IRQ_CLR_IDX, 32'hF);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test inline wake done");
    // pending enabled source with global enable clear: sleep is a no-op
    srcFlag <= 8'h01;
    n0 = nopCnt;
    sleep_now();
    chk(nopCnt - n0, 32'h1, "no-op count");
    chk({31'h0, oscDriverEn}, 32'h1, "osc kept");
    srcFlag <= 8'h00;
    apb(1'h0, swc_pkg::IRQ_STAT_IDX, 32'h0);
    chk(rd, 32'h8, "no-op event");
    $display("test no-op done");
    // global enable set: wake then one vector request
    apb(1'h1, swc_pkg::CTRL_IDX, 32'h1);
    n0 = vecCnt;
    sleep_now();
    srcFlag <= 8'h01;
    wait_run(200);
    srcFlag <= 8'h00;
    repeat (4) @(posedge ref_clk);
    chk(vecCnt - n0, 32'h1, "vector count");
    chk({19'h0, vectorAddr}, 32'(swc_pkg::IRQ_VECTOR), "vector address");
    apb(1'h1, swc_pkg::CTRL_IDX, 32'h0);
    $display("test vector done");
    // disabled source ignored; expiry wakes without reset
    apb(1'h1, swc_pkg::SRC_EN_IDX, 32'h0);
    n0 = rstCnt;
    sleep_now();
    srcFlag <= 8'h01;
    repeat (30) @(posedge ref_clk);
    chk({31'h0, coreStall}, 32'h1, "disabled source");
    wait_run(600);
    chk({31'h0, expiry_flag}, 32'h0, "expiry flag");
    chk(rstCnt - n0, 32'h0, "reset on expiry wake");
    srcFlag <= 8'h00;
    n = 0;
    while (rstCnt == n0 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, n > 300 && n < 600}, 32'h1, "watchdog restart");
    $display("test watchdog done");
    // master clear pulls the device out of sleep
    sleep_now();
    master_clear_pin <= 1'h0;
    repeat (3) @(posedge ref_clk);
    chk({30'h0, oscDriverEn, coreStall}, 32'h2, "master clear wake");
    master_clear_pin <= 1'h1;
    $display("test master clear done");
    close_out();
  end
endmodule
